//--- verilog/cdsc_params.svh
// Constants for the current DAC serial control block.
// Assumes inclusion by bare name from the package and cdsc_top.
`ifndef CDSC_PARAMS_SVH
`define CDSC_PARAMS_SVH

// Serial word layout
`define CDSC_WORD_W      24
`define CDSC_ADDR_W      8
`define CDSC_DATA_W      16
`define CDSC_ADDR_MSB    23
`define CDSC_ADDR_LSB    16

// Register addresses carried in the address field
`define CDSC_ADDR_NOP    8'h00
`define CDSC_ADDR_DATA   8'h01
`define CDSC_ADDR_RDBK   8'h02
`define CDSC_ADDR_CTRL   8'h03
`define CDSC_ADDR_SWRST  8'h04

// Control field positions and reset values
`define CDSC_CTRL_RANGE_LSB 0
`define CDSC_CTRL_DAISY_BIT 3
`define CDSC_CTRL_RST    16'h0000
`define CDSC_DATA_RST    16'h0000
`define CDSC_ZERO_CODE   16'h0000

// Timing: serial clock limit and settle time of a captured word
`define CDSC_SCLK_MAX_MHZ 30
`define CDSC_SYS_MHZ      125
`define CDSC_QUIET_CYC    2'h2
`define CDSC_FIFO_DEPTH   16

`endif

//--- verilog/cdsc_pkg.sv
// Types shared by the current DAC serial control block.
// Assumes cdsc_params.svh is on the include path.
`include "cdsc_params.svh"

package cdsc_pkg;

  typedef enum logic [1:0] {
    CDSC_RANGE_4_20 = 2'b00,
    CDSC_RANGE_0_20 = 2'b01,
    CDSC_RANGE_0_24 = 2'b10,
    CDSC_RANGE_RSVD = 2'b11
  } cdsc_range_e_t;

  typedef enum logic [1:0] {
    CDSC_RB_STATUS = 2'b00,
    CDSC_RB_DATA   = 2'b01,
    CDSC_RB_CTRL   = 2'b10,
    CDSC_RB_NONE   = 2'b11
  } cdsc_rb_sel_t;

  typedef struct packed {
    logic [`CDSC_ADDR_W-1:0] addr;
    logic [`CDSC_DATA_W-1:0] data;
  } cdsc_word_t;

  typedef struct packed {
    logic [11:0]   rsvd_hi;
    logic          daisy;
    logic          rsvd_lo;
    cdsc_range_e_t range;
  } cdsc_ctrl_t;

  // Analog-facing output bundle
  typedef struct packed {
    logic [`CDSC_DATA_W-1:0] code;
    cdsc_range_e_t           range;
    logic                    zero_scale;
  } cdsc_out_t;

endpackage : cdsc_pkg

//--- verilog/cdsc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps

module cdsc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } cdsc_fifo_st_t;

  cdsc_fifo_st_t q;
  cdsc_fifo_st_t d;
  logic          push;
  logic          pop;

  assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];

  always_comb begin
    d    = q;
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr        = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

endmodule // cdsc_fifo

//--- verilog/cdsc_top.sv
// Serial control front end of a single-channel current-output DAC.
// Assumes the host drives serial clock, data and load strobe pins and
// the analog core takes code/range through a valid/ready update port.
//
// Overview of operation
// - Pull alarm low on open loop or overtemperature
// - Clear input forces zero-scale output code
// - Load strobe rise transfers word to addressed register
// - Data register load updates output code
// - Shift one input bit per serial clock rise
// - Drive serial output only in readback/daisy modes
// - Words are 24 bits, MSB first
// - Word is 8-bit address then 16-bit data
// - Shifting ignores strobe; strobe takes last 24
`timescale 1ns/1ps
`include "cdsc_params.svh"

module cdsc_top #(
  parameter int FIFO_DEPTH = `CDSC_FIFO_DEPTH
) (
  // System clock, reset, enable
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  // Serial link pins
  input  wire logic                  sclk_i,
  input  wire logic                  latch_i,
  input  wire logic                  serial_data_in_i,
  output logic                       serial_data_out_o,
  output logic                       serial_data_out_oe_o,
  // Clear and fault pins
  input  wire logic                  clear_i,
  input  wire logic                  open_circuit_i,
  input  wire logic                  over_temp_i,
  output logic                       alarm_n_o,
  output logic                       alarm_oe_o,
  // Analog core update port
  output cdsc_pkg::cdsc_out_t        current_output_o,
  output logic                       upd_valid_o,
  input  wire logic                  upd_ready_i
);
  import cdsc_pkg::*;

  // Link domain state, clocked by the serial clock
  typedef struct packed {
    logic                     rst_m;
    logic                     rst_s;
    logic [`CDSC_WORD_W-1:0]  shreg;
    logic                     tgl;
  } cdsc_lnk_st_t;

  // System domain state
  typedef struct packed {
    logic                     sclk_m;
    logic                     sclk_s;
    logic                     sclk_p;
    logic                     latch_m;
    logic                     latch_s;
    logic                     latch_p;
    logic                     tgl_m;
    logic                     tgl_s;
    logic                     tgl_p;
    logic                     clr_m;
    logic                     clr_s;
    logic                     oc_m;
    logic                     oc_s;
    logic                     ot_m;
    logic                     ot_s;
    logic [1:0]               quiet;
    logic                     cap_pend;
    logic                     cap_valid;
    logic [`CDSC_WORD_W-1:0]  cap_word;
    logic [`CDSC_DATA_W-1:0]  data;
    cdsc_ctrl_t               ctrl;
    logic [`CDSC_WORD_W-1:0]  out_sr;
    logic                     ser_out;
    logic                     ser_out_oe;
    logic                     alarm_n;
    logic                     alarm_oe;
    cdsc_out_t                out;
    logic                     upd_valid;
  } cdsc_sys_st_t;

  cdsc_lnk_st_t            lq;
  cdsc_lnk_st_t            ld;
  cdsc_sys_st_t            q;
  cdsc_sys_st_t            d;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [`CDSC_WORD_W-1:0] fifo_out_data;
  cdsc_word_t              word;
  logic                    sclk_fall;
  logic                    latch_rise;

  // Link side: bits shift on every rise, strobe level plays no part
  always_comb begin
    ld       = lq;
    ld.rst_m = srst_i;
    ld.rst_s = lq.rst_m;
    if (lq.rst_s) begin
      ld.shreg = '0;
      ld.tgl   = 1'b0;
    end else begin
      ld.shreg = {lq.shreg[`CDSC_WORD_W-2:0], serial_data_in_i};
      ld.tgl   = ~lq.tgl;
    end
  end

  always_ff @(posedge sclk_i) begin
    lq <= ld;
  end

  // Captured words queue here while the analog side is busy
  cdsc_fifo #(
    .WIDTH (`CDSC_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (q.cap_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (q.cap_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // One pending update at a time; the analog side stalls the drain
  assign fifo_out_ready = !q.upd_valid;

  always_comb begin
    d          = q;
    word       = cdsc_word_t'(fifo_out_data);
    sclk_fall  = q.sclk_p & ~q.sclk_s;
    latch_rise = q.latch_s & ~q.latch_p;

    // Pin synchronisers
    d.sclk_m  = sclk_i;
    d.sclk_s  = q.sclk_m;
    d.sclk_p  = q.sclk_s;
    d.latch_m = latch_i;
    d.latch_s = q.latch_m;
    d.latch_p = q.latch_s;
    d.tgl_m   = lq.tgl;
    d.tgl_s   = q.tgl_m;
    d.tgl_p   = q.tgl_s;
    d.clr_m   = clear_i;
    d.clr_s   = q.clr_m;
    d.oc_m    = open_circuit_i;
    d.oc_s    = q.oc_m;
    d.ot_m    = over_temp_i;
    d.ot_s    = q.ot_m;

    // Shift register is captured only after the serial clock has gone quiet
    if (q.tgl_s != q.tgl_p) begin
      d.quiet = '0;
    end else if (q.quiet != `CDSC_QUIET_CYC) begin
      d.quiet = q.quiet + 1'b1;
    end

    if (q.cap_valid && fifo_in_ready) begin
      d.cap_valid = 1'b0;
    end
    // A full queue holds the word here and keeps the strobe pending
    if (q.cap_pend && (q.quiet == `CDSC_QUIET_CYC) && !d.cap_valid) begin
      d.cap_word  = lq.shreg;
      d.cap_valid = 1'b1;
      d.cap_pend  = 1'b0;
    end
    if (latch_rise) begin
      d.cap_pend = 1'b1;
      d.ser_out_oe = q.ctrl.daisy;
    end

    // Serial output moves on falling serial clock edges only
    if (sclk_fall && q.ser_out_oe) begin
      d.ser_out = q.ctrl.daisy ? lq.shreg[`CDSC_WORD_W-1] :
                                 q.out_sr[`CDSC_WORD_W-1];
      d.out_sr = {q.out_sr[`CDSC_WORD_W-2:0], 1'b0};
    end

    if (q.upd_valid && upd_ready_i) begin
      d.upd_valid = 1'b0;
    end

    // Address field selects the target register
    if (fifo_out_valid && fifo_out_ready) begin
      unique case (word.addr)
        `CDSC_ADDR_DATA: begin
          d.data      = word.data;
          d.upd_valid = 1'b1;
        end
        `CDSC_ADDR_CTRL: begin
          d.ctrl      = cdsc_ctrl_t'(word.data);
          d.upd_valid = 1'b1;
        end
        `CDSC_ADDR_SWRST: begin
          d.data      = `CDSC_DATA_RST;
          d.ctrl      = cdsc_ctrl_t'(`CDSC_CTRL_RST);
          d.upd_valid = 1'b1;
        end
        `CDSC_ADDR_RDBK: begin
          d.ser_out_oe = 1'b1;
          unique case (cdsc_rb_sel_t'(word.data[1:0]))
            CDSC_RB_STATUS: d.out_sr = {8'h00, 14'h0000, q.ot_s, q.oc_s};
            CDSC_RB_DATA:   d.out_sr = {8'h00, q.data};
            CDSC_RB_CTRL:   d.out_sr = {8'h00, q.ctrl};
            CDSC_RB_NONE:   d.out_sr = '0;
          endcase
        end
        default: begin
          d.upd_valid = q.upd_valid;
        end
      endcase
    end

    // Clear wins over any loaded code while it is held
    d.out.range      = d.ctrl.range;
    d.out.zero_scale = q.clr_s;
    d.out.code       = q.clr_s ? `CDSC_ZERO_CODE : d.data;
    if (q.clr_s != q.out.zero_scale) begin
      d.upd_valid = 1'b1;
    end

    // Open drain: enable pulls low, release lets the pull-up win
    d.alarm_n  = 1'b0;
    d.alarm_oe = q.oc_s | q.ot_s;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q      <= '0;
      q.data <= `CDSC_DATA_RST;
      q.ctrl <= cdsc_ctrl_t'(`CDSC_CTRL_RST);
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign serial_data_out_o    = q.ser_out;
  assign serial_data_out_oe_o = q.ser_out_oe;
  assign alarm_n_o            = q.alarm_n;
  assign alarm_oe_o           = q.alarm_oe;
  assign current_output_o     = q.out;
  assign upd_valid_o          = q.upd_valid;

endmodule // cdsc_top

//--- test/cdsc_top_props.sv
// Checker for the serial control block, watching top-level ports only.
// Assumes clk_sys_i domain with srst_i as the synchronous reset.
`timescale 1ns/1ps

module cdsc_top_props #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                clk_sys_i,
  input wire logic                srst_i,
  input wire logic                sclk_i,
  input wire logic                clear_i,
  input wire logic                open_circuit_i,
  input wire logic                over_temp_i,
  input wire logic                serial_data_out_o,
  input wire logic                serial_data_out_oe_o,
  input wire logic                alarm_n_o,
  input wire logic                alarm_oe_o,
  input wire cdsc_pkg::cdsc_out_t current_output_o,
  input wire logic                upd_valid_o,
  input wire logic                upd_ready_i
);
  import cdsc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_alarm_set: assert property (
    (open_circuit_i || over_temp_i)[*6] |-> alarm_oe_o)
    else $error("alarm not pulled on fault");
  chk_alarm_free: assert property (
    !(open_circuit_i || over_temp_i)[*6] |-> !alarm_oe_o)
    else $error("alarm not released");
  chk_alarm_low: assert property (
    alarm_oe_o |-> alarm_n_o == 1'b0)
    else $error("alarm drives high");
  chk_clear_zero: assert property (
    (clear_i && upd_ready_i)[*6] |-> current_output_o.zero_scale &&
      current_output_o.code == 16'h0000)
    else $error("clear did not force zero scale");
  chk_clear_back: assert property (
    $fell(clear_i) ##1 (!clear_i && upd_ready_i)[*8]
      |-> !current_output_o.zero_scale)
    else $error("zero scale kept after clear");
  chk_upd_hold: assert property (
    upd_valid_o && !upd_ready_i |=> upd_valid_o &&
      $stable(current_output_o))
    else $error("update dropped before ack");
  chk_out_with_upd: assert property (
    $changed(current_output_o) |-> upd_valid_o)
    else $error("output changed without update");
  chk_ser_out_fall: assert property (
    serial_data_out_oe_o && $changed(serial_data_out_o) |-> !sclk_i)
    else $error("serial out moved off falling edge");
endmodule // cdsc_top_props

bind cdsc_top cdsc_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk_i),
  .clear_i(clear_i), .open_circuit_i(open_circuit_i),
  .over_temp_i(over_temp_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .alarm_n_o(alarm_n_o),
  .alarm_oe_o(alarm_oe_o), .current_output_o(current_output_o),
  .upd_valid_o(upd_valid_o), .upd_ready_i(upd_ready_i));

//--- test/cdsc_host_model.sv
// Host serial master: shifts words, pulses the load strobe, reads back.
// Assumes half is set by the bench; 15 ns gives the 30 ns link clock.
`timescale 1ns/1ps

module cdsc_host_model (
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      latch_o,
  input wire logic  ser_out_i
);
  int half = 15;
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    latch_o = 1'b0;
  end

  // Leading junk bits show that only the last 24 count
  task automatic send(input logic [23:0] w, input int pre,
                      output logic [23:0] rd);
    rd = 24'h000000;
    for (int i = pre + 23; i >= 0; i--) begin
      sdi_o = (i > 23) ? ~w[23] : w[i];
      #(half);
      sclk_o = 1'b1;
      rd = {rd[22:0], ser_out_i};
      #(half);
      sclk_o = 1'b0;
    end
    // Extra look picks up the bit shifted at the last fall
    #(half);
    rd = {rd[22:0], ser_out_i};
    sdi_o = ~sdi_o;
    latch_o = 1'b1;
    #(3 * half);
    latch_o = 1'b0;
    #(half);
  endtask
endmodule // cdsc_host_model

//--- test/tb_cdsc_top.sv
// Self-checking bench for the serial control block.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_cdsc_top;
  import cdsc_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        clear_i = 1'b0;
  logic        open_circuit_i = 1'b0;
  logic        over_temp_i = 1'b0;
  logic        upd_ready_i = 1'b1;
  logic        sclk, latch, sdi, ser_out, ser_out_oe, alarm_n, alarm_oe,
               upd_valid;
  cdsc_out_t   cur;
  logic [23:0] rd;
  logic        g;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  // Released line shows the inverse so a stale bit cannot pass
  cdsc_host_model u_host (.sclk_o(sclk), .sdi_o(sdi), .latch_o(latch),
                          .ser_out_i(ser_out_oe ? ser_out : ~ser_out));
  cdsc_top #(.FIFO_DEPTH(16)) u_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
    .sclk_i(sclk), .latch_i(latch), .serial_data_in_i(sdi),
    .serial_data_out_o(ser_out), .serial_data_out_oe_o(ser_out_oe),
    .clear_i(clear_i), .open_circuit_i(open_circuit_i),
    .over_temp_i(over_temp_i), .alarm_n_o(alarm_n), .alarm_oe_o(alarm_oe),
    .current_output_o(cur), .upd_valid_o(upd_valid),
    .upd_ready_i(upd_ready_i));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_upd(output logic got);
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge clk_sys_i);
      got = (upd_valid === 1'b1);
    end
  endtask

  task automatic write(input logic [23:0] w, input int pre,
                       output logic got);
    logic [23:0] r;
    fork
      u_host.send(w, pre, r);
      begin
        @(posedge latch);
        wait_upd(got);
      end
    join
  endtask

  task automatic t_write;
    write(24'h01BEEF, 5, g);
    check({g, cur.zero_scale, cur.code}, {2'b10, 16'hBEEF});
    write(24'h030002, 0, g);
    check({g, cur.range}, {1'b1, CDSC_RANGE_0_24});
    write(24'h01FFFF, 0, g);
    check({g, cur.code}, {1'b1, 16'hFFFF});
  endtask

  task automatic t_unknown;
    logic [7:0] a [3] = '{8'h00, 8'h7F, 8'hFF};
    foreach (a[i]) begin
      write({a[i], 16'h1234}, 0, g);
      check(g, 1'b0);
    end
  endtask

  task automatic t_clear;
    @(negedge clk_sys_i) clear_i = 1'b1;
    wait_upd(g);
    check({g, cur.zero_scale, cur.code}, {2'b11, 16'h0000});
    @(negedge clk_sys_i) clear_i = 1'b0;
    wait_upd(g);
    check({g, cur.zero_scale, cur.code}, {2'b10, 16'hFFFF});
  endtask

  task automatic t_alarm;
    for (int f = 0; f < 2; f++) begin
      @(negedge clk_sys_i);
      {open_circuit_i, over_temp_i} = f[0] ? 2'b01 : 2'b10;
      repeat (8) @(negedge clk_sys_i);
      check({alarm_oe, alarm_n}, 2'b10);
      {open_circuit_i, over_temp_i} = 2'b00;
      repeat (8) @(negedge clk_sys_i);
      check(alarm_oe, 1'b0);
    end
  endtask

  task automatic t_readback;
    u_host.half = 60;
    check(ser_out_oe, 1'b0);
    write(24'h020001, 0, g);
    check(ser_out_oe, 1'b1);
    u_host.send(24'h000000, 0, rd);
    check(rd, 24'h00FFFF);
    repeat (20) @(negedge clk_sys_i);
    check(ser_out_oe, 1'b0);
    u_host.half = 15;
  endtask

  // Far side stalls while twenty words arrive; the excess must be lost
  // One decoded, 16 queued, one in capture; later strobes take the last word
  task automatic t_fill;
    int          n;
    logic [15:0] exp;
    n = 0;
    upd_ready_i = 1'b0;
    for (int i = 0; i < 20; i++) write({8'h01, 16'(i)}, 0, g);
    repeat (100) begin
      @(negedge clk_sys_i);
      if (upd_valid === 1'b1) begin
        exp = (n < 18) ? 16'(n) : 16'h0013;
        check(cur.code, exp);
        n++;
      end
      upd_ready_i = 1'b1;
    end
    check(24'(n), 24'h000013);
  endtask

  initial begin
    u_host.send(24'h000000, 0, rd);
    @(negedge clk_sys_i) srst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_write();
    t_unknown();
    t_clear();
    t_alarm();
    t_readback();
    t_fill();
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_cdsc_top
